// *** hw/spc_defs.svh ***
// offsets, field positions, reset values and clock divider counts
// assumes a word-per-register plain port with a byte-wide data path
`ifndef SPC_DEFS_SVH
`define SPC_DEFS_SVH

// register offsets on the plain port
`define SPC_OFS_CONTROL_ONE   3'h0
`define SPC_OFS_BUFFER        3'h1
`define SPC_OFS_BAUD          3'h2
`define SPC_OFS_STATUS        3'h3
`define SPC_OFS_IRQ_STATUS    3'h4
`define SPC_OFS_IRQ_MASK      3'h5

// control_one field positions
`define SPC_BIT_WRITE_COLLISION_FLAG          7
`define SPC_BIT_OVF           6
`define SPC_BIT_EN            5
`define SPC_BIT_CKP           4

// interrupt status bit positions
`define SPC_IRQ_DONE          0
`define SPC_IRQ_OVF           1
`define SPC_IRQ_WRITE_COLLISION_FLAG          2

// reset values
`define SPC_RST_CONTROL_ONE   8'h00
`define SPC_RST_BAUD          8'h00
`define SPC_RST_MASK          8'h00

// half-period of the master clock in system clocks
`define SPC_HALF_DIV4         10'h002
`define SPC_HALF_DIV16        10'h008
`define SPC_HALF_DIV64        10'h020

// pin slots in the pin bundle
`define SPC_PIN_CLK           0
`define SPC_PIN_OUT           1
`define SPC_PIN_IN            2
`define SPC_PIN_SEL           3

`endif

// *** hw/spc_pkg.sv ***
// types shared by the serial port control block
// assumes the offsets and fields come from spc_defs.svh
package spc_pkg;

  // port_mode_field encodings
  typedef enum logic [3:0] {
    SPC_SPI_M_DIV4   = 4'h0,
    SPC_SPI_M_DIV16  = 4'h1,
    SPC_SPI_M_DIV64  = 4'h2,
    SPC_SPI_M_TMR    = 4'h3,
    SPC_SPI_S_SEL    = 4'h4,
    SPC_SPI_S_NOSEL  = 4'h5,
    SPC_I2C_S_7      = 4'h6,
    SPC_I2C_S_10     = 4'h7,
    SPC_I2C_M_BAUD   = 4'h8,
    SPC_RSV_9        = 4'h9,
    SPC_SPI_M_BAUD   = 4'hA,
    SPC_I2C_M_FW     = 4'hB,
    SPC_RSV_C        = 4'hC,
    SPC_RSV_D        = 4'hD,
    SPC_I2C_S_7_SP   = 4'hE,
    SPC_I2C_S_10_SP  = 4'hF
  } spc_mode_t;

  // one register-port request
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } spc_req_t;

  // four pins: clock, data out, data in / two-wire data, select
  typedef struct packed {
    logic [3:0] out;
    logic [3:0] oe;
  } spc_pin_drv_t;

  // spi shift engine states
  typedef enum logic [1:0] {
    SPC_IDLE = 2'b01,
    SPC_RUN  = 2'b10
  } spc_state_t;

endpackage

// *** hw/spc_port.sv ***
// serial port control block: control register, spi engine, pin takeover
// assumes one 20 mhz clock, pins arrive unsynchronised from the pads
//
// Chosen here: the register addresses and the strobed register port.
`timescale 1ns/1ns
`include "spc_defs.svh"

module spc_port (
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire spc_pkg::spc_req_t req,
  output logic [7:0]             rdata,
  output logic                   irq,
  input  wire logic [3:0]        pin_in,
  output spc_pkg::spc_pin_drv_t  pin_drv,
  input  wire spc_pkg::spc_pin_drv_t gpio_drv,
  output logic [3:0]             gpio_in
);
  import spc_pkg::*;

  // software-visible state
  logic [7:0]  ctrl;          // serial_port_control_one
  logic [7:0]  rx_buf;        // transfer_buffer read side
  logic        buf_full;      // unread byte waiting
  logic [7:0]  baud;          // baud_divider_register
  logic [7:0]  irq_stat;      // sticky events
  logic [7:0]  irq_mask;      // same layout as irq_stat
  // engine state
  spc_state_t  state;
  logic [7:0]  shreg;         // shift_register
  logic        samp;          // bit caught on leading edge
  logic [3:0]  edges;         // clock edges seen in a byte
  logic [9:0]  div_cnt;       // master half-period counter
  logic        sck_m;         // master clock level
  // two-flop synchronisers for the pads
  logic [3:0]  pin_s1;
  logic [3:0]  pin_s2;
  logic        sck_prev;      // last synced clock, slave edges

  // field decode
  wire         en        = ctrl[`SPC_BIT_EN];
  wire         clock_polarity_bit       = ctrl[`SPC_BIT_CKP];
  wire         ovf       = ctrl[`SPC_BIT_OVF];
  wire [3:0]   mode      = ctrl[3:0];
  wire         spi_mst   = (mode == SPC_SPI_M_DIV4) ||
                           (mode == SPC_SPI_M_DIV16) ||
                           (mode == SPC_SPI_M_DIV64) ||
                           (mode == SPC_SPI_M_TMR) ||
                           (mode == SPC_SPI_M_BAUD);
  wire         spi_slv   = (mode == SPC_SPI_S_SEL) ||
                           (mode == SPC_SPI_S_NOSEL);
  wire         i2c_slv   = (mode == SPC_I2C_S_7) ||
                           (mode == SPC_I2C_S_10) ||
                           (mode == SPC_I2C_S_7_SP) ||
                           (mode == SPC_I2C_S_10_SP);
  wire         i2c_mst   = (mode == SPC_I2C_M_BAUD) ||
                           (mode == SPC_I2C_M_FW);
  wire         spi_on    = en && (spi_mst || spi_slv);
  wire         i2c_on    = en && (i2c_slv || i2c_mst);
  // select pin only gates the slave in mode 0100
  wire         use_sel   = (mode == SPC_SPI_S_SEL);
  wire         sel_n     = pin_s2[`SPC_PIN_SEL];
  wire         slv_act   = spi_on && spi_slv && !(use_sel && sel_n);

  // master half period from mode; timer source not present
  // so the timer-driven mode falls back to the fastest rate
  wire [9:0]   baud_half = {1'b0, baud, 1'b0} + 10'h002;
  wire [9:0]   half      = (mode == SPC_SPI_M_DIV16) ? `SPC_HALF_DIV16 :
                           (mode == SPC_SPI_M_DIV64) ? `SPC_HALF_DIV64 :
                           (mode == SPC_SPI_M_BAUD)  ? baud_half :
                           `SPC_HALF_DIV4;

  // register port decode
  wire         hit_ctrl  = (req.addr == `SPC_OFS_CONTROL_ONE);
  wire         hit_buf   = (req.addr == `SPC_OFS_BUFFER);
  wire         hit_baud  = (req.addr == `SPC_OFS_BAUD);
  wire         hit_stat  = (req.addr == `SPC_OFS_STATUS);
  wire         hit_istat = (req.addr == `SPC_OFS_IRQ_STATUS);
  wire         hit_mask  = (req.addr == `SPC_OFS_IRQ_MASK);
  wire         buf_wr    = req.wr && hit_buf;
  wire         buf_rd    = req.rd && hit_buf;

  // edges of the clock the engine runs on
  wire         m_tick    = (state == SPC_RUN) && spi_mst &&
                           (div_cnt == half - 10'h001);
  wire         sck_s     = pin_s2[`SPC_PIN_CLK];
  wire         s_edge    = slv_act && (sck_s != sck_prev);
  wire         any_edge  = m_tick || s_edge;
  // leading edge moves the clock away from its idle level
  wire         lead      = m_tick ? (sck_m == clock_polarity_bit) : (sck_prev == clock_polarity_bit);
  wire         byte_done = any_edge && !lead && (edges == 4'hF);
  // a slave byte is dropped while overflow stands or the buffer is full
  wire         drop      = spi_slv && (buf_full || ovf);
  wire         set_ovf   = byte_done && spi_slv && buf_full;
  wire         busy      = (state == SPC_RUN) ||
                           (slv_act && (edges != 4'h0));
  wire         set_write_collision_flag  = buf_wr && busy;

  // next control value: set by hardware wins over software clear
  logic [7:0]  next_ctrl;
  always_comb begin
    next_ctrl = ctrl;
    if (req.wr && hit_ctrl) begin
      // flags only clear by software, never set
      next_ctrl = {req.wdata[7] & ctrl[7], req.wdata[6] & ctrl[6],
                   req.wdata[5:0]};
    end
    if (set_write_collision_flag) begin
      next_ctrl[`SPC_BIT_WRITE_COLLISION_FLAG] = 1'b1;
    end
    if (set_ovf) begin
      next_ctrl[`SPC_BIT_OVF] = 1'b1;
    end
  end

  // interrupt events and read-to-clear; a new event wins
  wire [7:0]   irq_evt   = {5'h00, set_write_collision_flag, set_ovf, byte_done};
  wire [7:0]   next_istat = ((req.rd && hit_istat) ? 8'h00 : irq_stat)
                            | irq_evt;

  // read mux, answered one cycle after the strobe
  wire [7:0]   rd_mux    = hit_ctrl  ? ctrl :
                           hit_buf   ? rx_buf :
                           hit_baud  ? baud :
                           hit_stat  ? {6'h00, busy, buf_full} :
                           hit_istat ? irq_stat :
                           hit_mask  ? irq_mask :
                           8'h00;

  // pad synchronisers, first stage feeds only the second
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pin_s1 <= 4'h0;
      pin_s2 <= 4'h0;
    end else begin
      pin_s1 <= pin_in;
      pin_s2 <= pin_s1;
    end
  end

  // register file
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctrl     <= `SPC_RST_CONTROL_ONE;
      baud     <= `SPC_RST_BAUD;
      irq_mask <= `SPC_RST_MASK;
      irq_stat <= 8'h00;
      rdata    <= 8'h00;
    end else begin
      ctrl     <= next_ctrl;
      irq_stat <= next_istat;
      rdata    <= req.rd ? rd_mux : 8'h00;
      if (req.wr && hit_baud) begin
        baud <= req.wdata;
      end
      if (req.wr && hit_mask) begin
        irq_mask <= req.wdata;
      end
    end
  end

  // receive buffer; a completed byte beats a same-cycle read
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rx_buf   <= 8'h00;
      buf_full <= 1'b0;
    end else if (byte_done && !drop) begin
      // a slave byte needs a free buffer and overflow clear; a master byte always goes in
      rx_buf   <= {shreg[6:0], samp};
      buf_full <= 1'b1;
    end else if (buf_rd) begin
      buf_full <= 1'b0;
    end
  end

  // shift engine: master started by a buffer write, slave by edges
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state    <= SPC_IDLE;
      shreg    <= 8'h00;
      samp     <= 1'b0;
      edges    <= 4'h0;
      div_cnt  <= 10'h000;
      sck_m    <= 1'b0;
      sck_prev <= 1'b0;
    end else begin
      sck_prev <= sck_s;
      case (state)
        SPC_IDLE: begin
          sck_m   <= clock_polarity_bit;
          div_cnt <= 10'h000;
          if (buf_wr && !busy) begin
            shreg <= req.wdata;
            edges <= 4'h0;
            // a write in master mode starts a byte
            if (spi_on && spi_mst) begin
              state <= SPC_RUN;
            end
          end
        end
        SPC_RUN: begin
          div_cnt <= m_tick ? 10'h000 : div_cnt + 10'h001;
          if (m_tick) begin
            sck_m <= ~sck_m;
          end
          if (!spi_on || !spi_mst || byte_done) begin
            state <= SPC_IDLE;
          end
        end
        default: begin
          state <= SPC_IDLE;
        end
      endcase
      // common edge handling for both roles
      if (any_edge) begin
        edges <= edges + 4'h1;
        if (lead) begin
          samp <= pin_s2[`SPC_PIN_IN];
        end else begin
          shreg <= {shreg[6:0], samp};
        end
      end else if (!slv_act && spi_slv) begin
        // deselected slave restarts its byte count
        edges <= 4'h0;
      end
    end
  end

  // port-side pin drive
  spc_pin_drv_t port_drv;
  always_comb begin
    port_drv = '0;
    if (spi_on) begin
      // spi owns clock, out, in and select
      port_drv.out[`SPC_PIN_CLK] = spi_mst ? sck_m : 1'b0;
      port_drv.oe[`SPC_PIN_CLK]  = spi_mst;
      port_drv.out[`SPC_PIN_OUT] = shreg[7];
      port_drv.oe[`SPC_PIN_OUT]  = spi_mst || slv_act;
    end else if (i2c_on) begin
      // two-wire pins, open drain, low when driven
      // slave holds clock low while polarity is zero
      // master role never looks at polarity
      port_drv.oe[`SPC_PIN_CLK]  = i2c_slv && !clock_polarity_bit;
    end
  end

  // disabled port gives every pin back to gpio
  // enabled spi takes all four pins
  // enabled i2c takes clock and data pins only
  wire [3:0]   own       = spi_on ? 4'hF :
                           i2c_on ? 4'h5 : 4'h0;
  assign pin_drv.out = (port_drv.out & own) | (gpio_drv.out & ~own);
  assign pin_drv.oe  = (port_drv.oe  & own) | (gpio_drv.oe  & ~own);
  assign gpio_in     = pin_s2;

  // level interrupt from unmasked sticky events
  assign irq = |(irq_stat & irq_mask);

endmodule

// *** sim/spc_port_properties.sv ***
// checker for the serial port control block, bound to spc_port
// assumes software bits of control_one change only by register writes
`timescale 1ns/1ns
module spc_port_properties (
  input wire logic                  clock,
  input wire logic                  rst_n,
  input wire spc_pkg::spc_req_t     req,
  input wire logic [7:0]            rdata,
  input wire spc_pkg::spc_pin_drv_t pin_drv,
  input wire spc_pkg::spc_pin_drv_t gpio_drv
);
  import spc_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic [5:0] ctl;    // shadow of enable, polarity, mode
  logic [7:0] quiet;  // cycles since last buffer write, saturating
  logic       clean;  // no slave traffic since overflow cleared
  wire        en     = ctl[5];
  wire        clock_polarity_bit    = ctl[4];
  wire [3:0]  md     = ctl[3:0];
  wire        spi_m  = en && (md <= 4'h3 || md == 4'hA);
  wire        slow_m = en && md <= 4'h1;
  wire        i2c_s  = en && md[2:1] == 2'b11;
  wire        i2c_m  = en && (md == 4'h8 || md == 4'hB);
  wire        wr_ctl = req.wr && req.addr == 3'h0;
  wire        rd_ctl = req.rd && req.addr == 3'h0;
  // shadow registers; quiet saturates so long idles stay idle
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctl   <= 6'h00;
      quiet <= 8'hFF;
      clean <= 1'b1;
    end else begin
      if (wr_ctl) ctl <= req.wdata[5:0];
      if (req.wr && req.addr == 3'h1) quiet <= 8'h00;
      else if (quiet != 8'hFF) quiet <= quiet + 8'h01;
      // slave traffic may leave overflow set behind it
      if (en && (md == 4'h4 || md == 4'h5)) clean <= 1'b0;
      else if (wr_ctl && !req.wdata[6]) clean <= 1'b1;
    end
  end
  property p_off; !en |-> pin_drv == gpio_drv; endproperty
  a_off: assert property (p_off) else $error("pins not given back");
  property p_spi_pins; spi_m |-> pin_drv.oe[0] && !pin_drv.oe[2]; endproperty
  a_spi_pins: assert property (p_spi_pins) else $error("spi pins");
  property p_idle;
    slow_m && quiet > 8'hA0 && $past(ctl, 2) == ctl |-> pin_drv.out[0] == clock_polarity_bit;
  endproperty
  a_idle: assert property (p_idle) else $error("clock idle level");
  property p_stretch; i2c_s |-> pin_drv.oe[0] == !clock_polarity_bit; endproperty
  a_stretch: assert property (p_stretch) else $error("stretch");
  property p_i2c_m; i2c_m |-> pin_drv.oe[0] == 0 && pin_drv.oe[2] == 0;
  endproperty
  a_i2c_m: assert property (p_i2c_m) else $error("master polarity");
  property p_i2c_pins;
    i2c_s || i2c_m |-> pin_drv.out[0] == 0 && pin_drv.out[2] == 0 &&
      pin_drv.oe[2] == 0 && pin_drv.oe[3] == gpio_drv.oe[3];
  endproperty
  a_i2c_pins: assert property (p_i2c_pins) else $error("i2c pins");
  property p_ctl_rd; rd_ctl |=> rdata[5:0] == $past(ctl); endproperty
  a_ctl_rd: assert property (p_ctl_rd) else $error("control read");
  property p_no_ovf; clean && spi_m && rd_ctl |=> !rdata[6]; endproperty
  a_no_ovf: assert property (p_no_ovf) else $error("master overflow");
endmodule

// *** sim/spc_peer.sv ***
// spi peer on the pads: slave to a master port, master to a slave port
// assumes pull-ups on every pad, select active low
`timescale 1ns/1ns
module spc_peer (
  input wire logic                  clock,
  input wire logic                  role,
  input wire logic                  clock_polarity_bit,
  input wire spc_pkg::spc_pin_drv_t pin_drv,
  output logic [3:0]                pin_in
);
  import spc_pkg::*;
  logic       sck;    // own clock when acting as master
  logic       sel_n;  // own select, active low
  logic       clk_q;  // last seen clock pad
  logic [7:0] tx;     // outgoing byte, msb first
  logic [7:0] rx;     // byte captured from the port
  wire pad_clk = role ? sck : (pin_drv.oe[0] ? pin_drv.out[0] : 1'b1);
  wire pad_out = pin_drv.oe[1] ? pin_drv.out[1] : 1'b1;
  assign pin_in = {sel_n, (role && sel_n) ? 1'b1 : tx[7], pad_out, pad_clk};
  initial begin
    {sck, sel_n, clk_q, tx, rx} = {3'b010, 8'hFF, 8'h00};
  end
  // slave role: capture on leading edge, shift on trailing edge
  always @(posedge clock) begin
    clk_q <= pad_clk;
    if (!role && pad_clk != clk_q) begin
      if (pad_clk != clock_polarity_bit) rx <= {rx[6:0], pad_out};
      else tx <= {tx[6:0], 1'b1};
    end
  end
  // master role: half sets the pace, slow or prompt
  task xfer(input logic [7:0] b, input int half);
    @(posedge clock) {sck, sel_n, tx} <= {clock_polarity_bit, 1'b0, b};
    repeat (half) @(posedge clock);
    repeat (8) begin
      sck <= ~clock_polarity_bit;
      repeat (half) @(posedge clock);
      sck <= clock_polarity_bit;
      tx <= {tx[6:0], 1'b1};
      repeat (half) @(posedge clock);
    end
    sel_n <= 1'b1;
  endtask
endmodule

// *** sim/testbench.sv ***
// top bench: register tasks, spi transfers both ways, interrupts
// assumes the checker and peer files are compiled before this one
`timescale 1ns/1ns
module testbench;
  import spc_pkg::*;
  logic clock, rst_n, role, clock_polarity_bit, irq;
  logic [7:0] rdata, d;
  logic [3:0] pin_in, gpio_in;
  spc_req_t req;
  spc_pin_drv_t pin_drv, gpio_drv;
  int miscompares, total_checks;
  spc_port u_dut (.clock(clock), .rst_n(rst_n), .req(req), .rdata(rdata),
    .irq(irq), .pin_in(pin_in), .pin_drv(pin_drv), .gpio_drv(gpio_drv),
    .gpio_in(gpio_in));
  spc_peer u_peer (.clock(clock), .role(role), .clock_polarity_bit(clock_polarity_bit), .pin_drv(pin_drv),
    .pin_in(pin_in));
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  task results;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one strobe cycle, then an idle cycle before the next request
  task wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clock) req <= {a, v, 2'b10};
    @(posedge clock) req <= '0;
  endtask
  task rdc(input logic [2:0] a, input logic [7:0] e);
    @(posedge clock) req <= {a, 8'h00, 2'b01};
    @(posedge clock) req <= '0;
    #1 d = rdata;
    chk(d, e);
  endtask
  // bounded poll of the busy flag
  task idle;
    for (int n = 0; n < 300; n++) begin
      @(posedge clock) req <= {3'h3, 8'h00, 2'b01};
      @(posedge clock) req <= '0;
      #1 if (rdata[1] === 1'b0) return;
    end
    miscompares++;
    results;
  endtask
  initial begin
    {rst_n, role, clock_polarity_bit, req, gpio_drv} = {3'b000, 13'h0000, 8'hC3};
    miscompares = 0;
    total_checks = 0;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    rdc(3'h0, 8'h00);
    rdc(3'h5, 8'h00);
    chk(pin_drv, gpio_drv);
    chk({4'h0, gpio_in}, {4'h0, pin_in});
    wr(3'h7, 8'hFF);
    rdc(3'h7, 8'h00);
    wr(3'h2, 8'h5A);
    rdc(3'h2, 8'h5A);
    for (int i = 0; i < 32; i++) begin
      wr(3'h0, {3'b001, i[4:0]});
      rdc(3'h0, {3'b001, i[4:0]});
    end
    wr(3'h0, 8'h00);
    // let the control write settle before looking at the pads
    #1 chk(pin_drv, gpio_drv);
    wr(3'h5, 8'h01);
    for (int c = 0; c < 2; c++) begin
      clock_polarity_bit <= c[0];
      wr(3'h0, {3'b001, c[0], 4'h1});
      // a polarity change moves the idle clock once; let the peer
      // see that stray edge before its first byte is loaded
      repeat (3) @(posedge clock);
      u_peer.tx <= 8'hA5;
      wr(3'h1, 8'h3C);
      wr(3'h1, 8'hFF);
      idle;
      rdc(3'h1, 8'hA5);
      chk(u_peer.rx, 8'h3C);
      chk({7'h00, irq}, 8'h01);
      rdc(3'h4, 8'h05);
      chk({7'h00, irq}, 8'h00);
      rdc(3'h0, {3'b101, c[0], 4'h1});
      wr(3'h0, {3'b001, c[0], 4'h1});
      @(posedge clock) u_peer.tx <= 8'h7E;
      wr(3'h1, 8'h81);
      idle;
      // unread byte stays; a master overwrites it with the next one
      @(posedge clock) u_peer.tx <= 8'h66;
      wr(3'h1, 8'h18);
      idle;
      rdc(3'h0, {3'b001, c[0], 4'h1});
      rdc(3'h1, 8'h66);
      rdc(3'h4, 8'h01);
    end
    {role, clock_polarity_bit} <= 2'b10;
    wr(3'h5, 8'h00);
    wr(3'h0, 8'h24);
    u_peer.xfer(8'h5A, 6);
    u_peer.xfer(8'hC3, 6);
    repeat (4) @(posedge clock);
    chk({7'h00, irq}, 8'h00);
    rdc(3'h0, 8'h64);
    rdc(3'h1, 8'h5A);
    wr(3'h5, 8'h02);
    #1 chk({7'h00, irq}, 8'h01);
    wr(3'h0, 8'h24);
    u_peer.xfer(8'h11, 20);
    repeat (4) @(posedge clock);
    rdc(3'h1, 8'h11);
    rdc(3'h0, 8'h24);
    results;
  end
endmodule
bind spc_port spc_port_properties u_prop (.clock(clock), .rst_n(rst_n),
  .req(req), .rdata(rdata), .pin_drv(pin_drv), .gpio_drv(gpio_drv));
